//--- common/pcfl_regs.vh
// Constants for the peak current foldback limiter.
// Assumes currents in milliamperes (signed magnitude handled by caller) and a 1 ms control tick.
`ifndef PCFL_REGS_VH
`define PCFL_REGS_VH
`define PCFL_CUR_W 14
`define PCFL_ACC_W 40
`define PCFL_RATED_MA 14'h1_770
`define PCFL_PEAK_MAX_MA 14'h3_A98
`define PCFL_LIMIT_A2MS 40'h00_0005_C490
`define PCFL_TP_MAX_MS 16'h7_530
`define PCFL_TICK_US 32'h0000_03E8
`define PCFL_CLK_MHZ 32'h0000_0028
`define PCFL_TICK_CYC (`PCFL_TICK_US * `PCFL_CLK_MHZ)
`define PCFL_MA2_PER_A2 40'h00_000F_4240
`endif

//--- design/pcfl_limiter.v
// Peak current foldback limiter: squared-current accumulator with clamp and thermal cutoff.
// Assumes current command and measurement come from logic on CLK_SYS; the thermal flag is a pin.
// Functional notes
// R1: Current above continuous raises the accumulator.
// R2: Current below continuous lowers the accumulator.
// R3: At limit clamp command to continuous current.
// R4: Command never exceeds configured peak current.
// R5: Rated current constant fixed at 6 A.
// R6: Limit equals (peak^2 - rated^2) times peak time.
// R7: Peak current setting capped at 15 A.
// R8: Peak time over computed limit uses limit.
// R9: Peak time never above thirty seconds.
// R10: Overtemperature shuts off motor current.
// R11: Each tick add I^2 - Ic^2, saturating.
`timescale 1ns/1ps
`default_nettype none
`include "pcfl_regs.vh"

module pcfl_limiter #(
  parameter TICK_CYC = `PCFL_TICK_CYC
) (
  input wire CLK_SYS,
  input wire RSTN,
  input wire CE,
  input wire [13:0] CURRENT_CMD,
  input wire [13:0] CURRENT_MEAS,
  input wire [13:0] PEAK_CURRENT_SETTING,
  input wire [13:0] CONTINUOUS_CURRENT_SETTING,
  input wire [15:0] PEAK_TIME_SETTING,
  input wire OVERTEMP,
  output wire [13:0] CURRENT_OUT,
  output wire FOLDBACK_ACTIVE,
  output wire THERMAL_SHUTDOWN,
  output wire [15:0] PEAK_TIME_EFFECTIVE
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset is applied at once but released through two flops to avoid recovery races.
  reg rst_s1_ff;
  reg rst_s2_ff;
  wire rst_n;

  assign rst_n = rst_s2_ff;

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The thermal flag is a pin, so only the second flop is read by logic.
  reg ot_s1_ff;
  reg ot_s2_ff;

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ot_s1_ff <= 1'b0;
      ot_s2_ff <= 1'b0;
    end else if (CE) begin
      ot_s1_ff <= OVERTEMP;
      ot_s2_ff <= ot_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings cleanup, all combinational from stable configuration.
  reg [13:0] ip_ma;
  reg [13:0] ic_ma;
  wire [13:0] ir_ma;
  wire [27:0] ip_sq;
  wire [27:0] ir_sq;
  wire [27:0] ic_sq;
  reg [27:0] ovr_sq;

  assign ir_ma = `PCFL_RATED_MA; // [R5]
  assign ip_sq = ip_ma * ip_ma;
  assign ir_sq = ir_ma * ir_ma;
  assign ic_sq = ic_ma * ic_ma;

  always @* begin
    ip_ma = PEAK_CURRENT_SETTING;
    if (PEAK_CURRENT_SETTING > `PCFL_PEAK_MAX_MA) begin
      ip_ma = `PCFL_PEAK_MAX_MA; // [R7]
    end
  end

  always @* begin
    ic_ma = CONTINUOUS_CURRENT_SETTING;
    if (CONTINUOUS_CURRENT_SETTING > ip_ma) begin
      ic_ma = ip_ma;
    end
  end

  // A peak at or below rated current leaves a unit term, so the thirty-second cap rules.
  always @* begin
    ovr_sq = 28'h000_0001;
    if (ip_sq > ir_sq) begin
      ovr_sq = ip_sq - ir_sq; // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The preset limit is in A^2*ms; scaled to mA^2*ms to match the squared samples.
  wire [39:0] limit_acc;
  wire [39:0] ovr_ext;
  wire [39:0] tp_calc_w;
  wire [39:0] tp_max_ext;
  reg [15:0] tp_calc;
  reg [15:0] tp_eff;
  wire [39:0] tp_ext;
  wire [79:0] acc_lim_w;
  wire [39:0] acc_lim;

  assign limit_acc = `PCFL_LIMIT_A2MS * `PCFL_MA2_PER_A2; // [R6]
  assign ovr_ext = {12'h000, ovr_sq};
  // The divider is large but only settles once per configuration change.
  assign tp_calc_w = limit_acc / ovr_ext; // [R6]
  assign tp_max_ext = {24'h00_0000, `PCFL_TP_MAX_MS};

  always @* begin
    tp_calc = tp_calc_w[15:0];
    if (tp_calc_w > tp_max_ext) begin
      tp_calc = `PCFL_TP_MAX_MS; // [R9]
    end
  end

  always @* begin
    tp_eff = PEAK_TIME_SETTING;
    if (PEAK_TIME_SETTING > tp_calc) begin
      tp_eff = tp_calc; // [R8]
    end
  end

  assign tp_ext = {24'h00_0000, tp_eff};
  assign acc_lim_w = ovr_ext * tp_ext;
  assign acc_lim = acc_lim_w[39:0]; // [R6]

  ////////////////////////////////////////////////////////////////////////////
  // Control period counter; the accumulator moves only on its last count.
  localparam [31:0] TICK_LAST = TICK_CYC - 1;
  reg [31:0] tick_cnt_ff;
  reg [31:0] nxt_tick_cnt;
  wire tick;

  assign tick = (tick_cnt_ff == TICK_LAST);

  always @* begin
    nxt_tick_cnt = tick_cnt_ff + 32'h0000_0001;
    if (tick) begin
      nxt_tick_cnt = 32'h0000_0000;
    end
  end

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else if (CE) begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator in mA^2*ms, saturating at zero and at the limit.
  reg [39:0] acc_ff;
  reg [39:0] nxt_acc;
  wire [27:0] meas_sq;
  wire above;
  wire [39:0] up_d;
  wire [39:0] dn_d;
  wire [39:0] head;

  assign meas_sq = CURRENT_MEAS * CURRENT_MEAS;
  assign above = (CURRENT_MEAS > ic_ma);
  assign up_d = {12'h000, meas_sq - ic_sq};
  assign dn_d = {12'h000, ic_sq - meas_sq};
  assign head = acc_lim - acc_ff;

  always @* begin
    nxt_acc = acc_ff;
    if (above) begin
      if (head <= up_d) begin
        nxt_acc = acc_lim; // [R1] [R11]
      end else begin
        nxt_acc = acc_ff + up_d; // [R1] [R11]
      end
    end else begin
      if (acc_ff <= dn_d) begin
        nxt_acc = 40'h00_0000_0000; // [R2] [R11]
      end else begin
        nxt_acc = acc_ff - dn_d; // [R2] [R11]
      end
    end
    // A lowered limit pulls the total down with it, so no wrap can follow.
    if (nxt_acc > acc_lim) begin
      nxt_acc = acc_lim;
    end
  end

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 40'h00_0000_0000;
    end else if (CE && tick) begin
      acc_ff <= nxt_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clamp order: peak first, then foldback, thermal cutoff overrides both.
  wire fold;
  reg [13:0] cmd_pk;
  reg [13:0] cmd_fb;
  reg [13:0] nxt_out;

  assign fold = (acc_ff >= acc_lim);

  always @* begin
    cmd_pk = CURRENT_CMD;
    if (CURRENT_CMD > ip_ma) begin
      cmd_pk = ip_ma; // [R4]
    end
  end

  always @* begin
    cmd_fb = cmd_pk;
    if (fold && cmd_pk > ic_ma) begin
      cmd_fb = ic_ma; // [R3]
    end
  end

  always @* begin
    nxt_out = cmd_fb;
    if (ot_s2_ff) begin
      nxt_out = 14'h0000; // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops; every data output leaves the block from a register.
  reg [13:0] out_ff;
  reg fold_ff;
  reg shut_ff;
  reg [15:0] pte_ff;

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      out_ff <= 14'h0000;
      fold_ff <= 1'b0;
      shut_ff <= 1'b0;
      pte_ff <= 16'h0000;
    end else if (CE) begin
      out_ff <= nxt_out; // [R10]
      fold_ff <= fold; // [R3]
      shut_ff <= ot_s2_ff; // [R10]
      pte_ff <= tp_eff; // [R8]
    end
  end

  assign CURRENT_OUT = out_ff;
  assign FOLDBACK_ACTIVE = fold_ff;
  assign THERMAL_SHUTDOWN = shut_ff;
  assign PEAK_TIME_EFFECTIVE = pte_ff;
endmodule
`default_nettype wire

//--- verif/pcfl_stage.sv
// Power stage model: phase current follows the delivered command one cycle late.
// Assumes the bench raises heat to model a hot drive.
`timescale 1ns/1ps
`default_nettype none
module pcfl_stage (
  input wire logic clk,
  input wire logic heat,
  input wire logic [13:0] drive,
  output logic [13:0] meas,
  output logic hot
);
  always @(posedge clk) meas <= drive;
  assign hot = heat;
endmodule
`default_nettype wire

//--- verif/pcfl_limiter_assertions.sv
// Port checker for the limiter.
// Assumes CE stays high, since a frozen block would stretch every latency.
`timescale 1ns/1ps
`default_nettype none
module pcfl_chk (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic OVERTEMP,
  input wire logic FOLDBACK_ACTIVE,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic [13:0] CURRENT_CMD,
  input wire logic [13:0] CURRENT_MEAS,
  input wire logic [13:0] PEAK_CURRENT_SETTING,
  input wire logic [13:0] CONTINUOUS_CURRENT_SETTING,
  input wire logic [13:0] CURRENT_OUT,
  input wire logic [15:0] PEAK_TIME_SETTING,
  input wire logic [15:0] PEAK_TIME_EFFECTIVE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  property p_pk; CURRENT_OUT <= $past(PEAK_CURRENT_SETTING) && CURRENT_OUT <= 14'h3A98; endproperty
  a_pk: assert property (p_pk) else $error("out above peak");
  property p_fb; FOLDBACK_ACTIVE && $past(FOLDBACK_ACTIVE) |-> CURRENT_OUT <= $past(CONTINUOUS_CURRENT_SETTING);
  endproperty
  a_fb: assert property (p_fb) else $error("no clamp");
  property p_ps; !THERMAL_SHUTDOWN && !$past(THERMAL_SHUTDOWN) && $past(CURRENT_CMD) <=
    $past(CONTINUOUS_CURRENT_SETTING) && $past(CURRENT_CMD) <= $past(PEAK_CURRENT_SETTING) |->
    CURRENT_OUT == $past(CURRENT_CMD); endproperty
  a_ps: assert property (p_ps) else $error("command lost");
  property p_sd; THERMAL_SHUTDOWN && $past(THERMAL_SHUTDOWN) |-> CURRENT_OUT == 14'h0000; endproperty
  a_sd: assert property (p_sd) else $error("current while hot");
  property p_ot; $rose(OVERTEMP) |-> ##[1:3] THERMAL_SHUTDOWN; endproperty
  a_ot: assert property (p_ot) else $error("late cutoff");
  property p_up; $rose(FOLDBACK_ACTIVE) |-> $past(CURRENT_MEAS, 2) > CONTINUOUS_CURRENT_SETTING; endproperty
  a_up: assert property (p_up) else $error("bad rise");
  property p_dn; $fell(FOLDBACK_ACTIVE) |-> $past(CURRENT_MEAS, 2) < CONTINUOUS_CURRENT_SETTING; endproperty
  a_dn: assert property (p_dn) else $error("bad fall");
  property p_pt; PEAK_TIME_EFFECTIVE <= 16'h7530; endproperty
  a_pt: assert property (p_pt) else $error("time above cap");
endmodule
bind pcfl_limiter pcfl_chk u_chk(.*);
`default_nettype wire

//--- verif/tb_peak_current_foldback_limiter.sv
// Bench for the limiter with a power stage model.
// Assumes a short tick so the accumulator moves within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_peak_current_foldback_limiter;
  logic clk = 0, rstn = 0, heat = 0, fb, sd, hot;
  logic [13:0] cmd = 0, pk = 14'h2710, ct = 14'h1388, out, meas;
  logic [15:0] tp = 16'h0002, pte;
  int fails = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  pcfl_limiter #(.TICK_CYC(4)) dut_u(.CLK_SYS(clk), .RSTN(rstn), .CE(1'b1), .CURRENT_CMD(cmd),
    .CURRENT_MEAS(meas), .PEAK_CURRENT_SETTING(pk), .CONTINUOUS_CURRENT_SETTING(ct), .PEAK_TIME_SETTING(tp),
    .OVERTEMP(hot), .CURRENT_OUT(out), .FOLDBACK_ACTIVE(fb), .THERMAL_SHUTDOWN(sd), .PEAK_TIME_EFFECTIVE(pte));
  pcfl_stage stg_u(.clk(clk), .heat(heat), .drive(out), .meas(meas), .hot(hot));
  task chk(string n, logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task go(logic [13:0] c, int n);
    @(posedge clk) cmd <= c;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task t_fold;
    go(14'h3FFF, 2);
    chk("peak", out, pk);
    for (int i = 0; i < 99 && fb !== 1; i++) @(posedge clk);
    go(14'h3FFF, 2);
    chk("fold", fb, 1);
    chk("cont", out, ct);
    go(14'h0, 1);
    for (int i = 0; i < 99 && fb !== 0; i++) @(posedge clk);
    #1 chk("release", fb, 0);
  endtask
  task setpt(logic [13:0] p, logic [15:0] t, e);
    @(posedge clk) pk <= p;
    tp <= t;
    repeat (40) @(posedge clk);
    #1 chk("ptime", pte, e);
  endtask
  task t_time;
    setpt(14'h3A98, 16'hFFFF, 16'h07D0);
    setpt(14'h1770, 16'hFFFF, 16'h7530);
    setpt(14'h3FFF, 16'h0064, 16'h0064);
    go(14'h3FFF, 2);
    chk("max", out, 14'h3A98);
  endtask
  task t_heat;
    @(posedge clk) heat <= 1;
    go(14'h0FA0, 6);
    chk("cut", sd, 1);
    chk("zero", out, 0);
    @(posedge clk) heat <= 0;
    go(14'h0FA0, 6);
    chk("clear", sd, 0);
    chk("back", out, 14'h0FA0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    repeat (5) @(posedge clk);
    t_fold;
    t_time;
    t_heat;
    conclude;
  end
  initial begin
    #200000;
    fails++;
    conclude;
  end
endmodule
`default_nettype wire
